// File: design/dtc_pin_sync.sv
`timescale 1ns/1ps
// ****************************************
// Pin synchroniser with agreement filter
// ****************************************
module dtc_pin_sync (
  // Clock, reset, enable
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // Pin side
  input  wire logic pin_i,
  // Synchronised side
  output logic      level_o,
  output logic      fall_o
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Three flops; first stage feeds only the second
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end else if (ce_i) begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a new level only when stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      level_o <= 1'b1;
      fall_o  <= 1'b0;
    end else if (ce_i) begin
      fall_o <= (stage2 == stage3) && level_o && !stage3;
      if (stage2 == stage3) begin
        level_o <= stage3;
      end
    end
  end

endmodule

// File: design/dtc_pkg.sv
// ****************************************
// Dual timer/counter shared constants
// ****************************************
package dtc_pkg;

  // ****************************************
  // Register addresses on the special function bus
  // ****************************************
  localparam logic [7:0] ADDR_TIMER_CONTROL    = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE       = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_LOW_BYTE  = 8'h8a;
  localparam logic [7:0] ADDR_TIMER1_LOW_BYTE  = 8'h8b;
  localparam logic [7:0] ADDR_TIMER0_HIGH_BYTE = 8'h8c;
  localparam logic [7:0] ADDR_TIMER1_HIGH_BYTE = 8'h8d;

  // ****************************************
  // Timer control register fields
  // ****************************************
  localparam int CTL_OVF_ONE  = 7;
  localparam int CTL_RUN_ONE  = 6;
  localparam int CTL_OVF_ZERO = 5;
  localparam int CTL_RUN_ZERO = 4;
  localparam int CTL_IRQ_ONE  = 3;
  localparam int CTL_TYPE_ONE = 2;
  localparam int CTL_IRQ_ZERO = 1;
  localparam int CTL_TYPE_ZERO = 0;

  // ****************************************
  // Timer mode register fields
  // ****************************************
  localparam int MOD_GATE_ONE = 7;
  localparam int MOD_CT_ONE   = 6;
  localparam int MOD_M_ONE_HI = 5;
  localparam int MOD_M_ONE_LO = 4;
  localparam int MOD_GATE_ZERO = 3;
  localparam int MOD_CT_ZERO   = 2;
  localparam int MOD_M_ZERO_HI = 1;
  localparam int MOD_M_ZERO_LO = 0;

  // Mode field encodings
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // Reset values of all bus registers
  localparam logic [7:0] REG_RESET = 8'h00;

  // ****************************************
  // Timing: one machine cycle in processor clocks
  // ****************************************
  localparam int         MC_CLOCKS = 12;
  localparam logic [3:0] MC_LAST   = 4'(MC_CLOCKS - 1);
  localparam logic [3:0] MC_FIRST  = 4'h0;

  // Index of each pin in the synchroniser bank
  localparam int PIN_CNT_ZERO = 0;
  localparam int PIN_CNT_ONE  = 1;
  localparam int PIN_IRQ_ZERO = 2;
  localparam int PIN_IRQ_ONE  = 3;
  localparam int PIN_COUNT    = 4;

endpackage

// File: design/dtc_timer.sv
`timescale 1ns/1ps
// Operation
// - Timer operation counts once per machine cycle of twelve clocks.
// - Counter operation counts only on a falling edge of the count input.
// - Edge detection spans two machine cycles; no duty-cycle limit.
// - Each timer runs only while its run bit is set.
// - Mode 0 is 13 bits; low byte keeps 5 bits, upper 3 zero.
// - Mode 1 is a full 16-bit counter of high and low byte.
// - Mode 2 counts low byte, reloads it from high byte on overflow.
// - Mode 3 stops timer 1 and splits timer 0 into two 8-bit halves.
// - Split low half uses timer 0 controls; high half uses timer 1 run.
// - With gate set, counting needs run bit and the gating pin.
// - Counter/timer select bit 1 picks counter, 0 picks timer.
// - Mode register: upper nibble timer 1, lower nibble timer 0.
// - Overflow flags set on overflow, cleared by software or service.
// - External interrupt flags set on falling edge, cleared on service.
// - Type bits choose falling edge or low level triggering.
// - Type bit 0 means low level, 1 means falling edge.
module dtc_timer (
  // Clock, reset, enable
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  // Special function register bus
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_we_i,
  input  wire logic       sfr_re_i,
  output logic      [7:0] sfr_rdata_o,
  // Routed pins
  input  wire logic       count_input_zero_i,
  input  wire logic       count_input_one_i,
  input  wire logic       external_irq_input_zero_i,
  input  wire logic       external_irq_input_one_i,
  // Service acknowledges from the interrupt logic
  input  wire logic       ack_timer_zero_i,
  input  wire logic       ack_timer_one_i,
  input  wire logic       ack_ext_irq_zero_i,
  input  wire logic       ack_ext_irq_one_i,
  // Flag view
  output logic      [7:0] timer_control_o
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] timer_control;
  logic [7:0] timer_mode;
  logic [7:0] timer0_low_byte;
  logic [7:0] timer0_high_byte;
  logic [7:0] timer1_low_byte;
  logic [7:0] timer1_high_byte;
  logic [3:0] mc_count;
  logic [1:0] cnt_sample;
  logic [1:0] cnt_prev;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [dtc_pkg::PIN_COUNT-1:0] pin_raw;
  logic [dtc_pkg::PIN_COUNT-1:0] pin_level;
  logic [dtc_pkg::PIN_COUNT-1:0] pin_fall;

  assign pin_raw = {external_irq_input_one_i, external_irq_input_zero_i,
                    count_input_one_i, count_input_zero_i};

  // One synchroniser per routed pin
  generate
    for (genvar gi = 0; gi < dtc_pkg::PIN_COUNT; gi++) begin : g_pin
      dtc_pin_sync u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .pin_i   (pin_raw[gi]),
        .level_o (pin_level[gi]),
        .fall_o  (pin_fall[gi])
      );
    end
  endgenerate

  // ****************************************
  // Field decode
  // ****************************************
  logic [1:0] mode_zero;
  logic [1:0] mode_one;
  logic       run_bit_zero;
  logic       run_bit_one;
  logic       split;

  assign mode_one  = timer_mode[dtc_pkg::MOD_M_ONE_HI:dtc_pkg::MOD_M_ONE_LO];
  assign mode_zero = timer_mode[dtc_pkg::MOD_M_ZERO_HI:dtc_pkg::MOD_M_ZERO_LO];
  assign run_bit_zero = timer_control[dtc_pkg::CTL_RUN_ZERO];
  assign run_bit_one  = timer_control[dtc_pkg::CTL_RUN_ONE];
  assign split        = (mode_zero == dtc_pkg::MODE_SPLIT);

  // Bus write strobes, frozen with the clock enable
  logic wr_ctl;
  logic wr_mod;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;

  assign wr_ctl = ce_i && sfr_we_i
                  && (sfr_addr_i == dtc_pkg::ADDR_TIMER_CONTROL);
  assign wr_mod = ce_i && sfr_we_i
                  && (sfr_addr_i == dtc_pkg::ADDR_TIMER_MODE);
  assign wr_tl0 = ce_i && sfr_we_i
                  && (sfr_addr_i == dtc_pkg::ADDR_TIMER0_LOW_BYTE);
  assign wr_th0 = ce_i && sfr_we_i
                  && (sfr_addr_i == dtc_pkg::ADDR_TIMER0_HIGH_BYTE);
  assign wr_tl1 = ce_i && sfr_we_i
                  && (sfr_addr_i == dtc_pkg::ADDR_TIMER1_LOW_BYTE);
  assign wr_th1 = ce_i && sfr_we_i
                  && (sfr_addr_i == dtc_pkg::ADDR_TIMER1_HIGH_BYTE);

  // ****************************************
  // Machine cycle prescaler
  // ****************************************
  logic mc_tick;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mc_count <= dtc_pkg::MC_FIRST;
    end else if (ce_i) begin
      mc_count <= (mc_count == dtc_pkg::MC_LAST) ? dtc_pkg::MC_FIRST
                                                 : mc_count + 4'h1;
    end
  end

  assign mc_tick = ce_i && (mc_count == dtc_pkg::MC_LAST);

  // ****************************************
  // Count input edge detection
  // ****************************************
  // sample once per machine cycle, compare two samples
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_sample <= 2'h3;
      cnt_prev   <= 2'h3;
    end else if (mc_tick) begin
      cnt_sample <= {pin_level[dtc_pkg::PIN_CNT_ONE],
                     pin_level[dtc_pkg::PIN_CNT_ZERO]};
      cnt_prev   <= cnt_sample;
    end
  end

  // a one-to-zero change between samples is one count
  logic [1:0] cnt_fall;
  assign cnt_fall = mc_tick ? (cnt_prev & ~cnt_sample) : 2'h0;

  // ****************************************
  // Increment enables
  // ****************************************
  logic open_zero;
  logic open_one;
  logic inc_zero;
  logic inc_one;
  logic inc_th0;

  // run bit; gate adds the gating pin level
  assign open_zero = run_bit_zero && (!timer_mode[dtc_pkg::MOD_GATE_ZERO]
                     || pin_level[dtc_pkg::PIN_IRQ_ZERO]);
  assign open_one  = run_bit_one && (!timer_mode[dtc_pkg::MOD_GATE_ONE]
                     || pin_level[dtc_pkg::PIN_IRQ_ONE]);
  assign inc_zero = open_zero && (timer_mode[dtc_pkg::MOD_CT_ZERO]
                    ? cnt_fall[0] : mc_tick);
  // timer 1 halts in mode 3
  assign inc_one  = open_one && (mode_one != dtc_pkg::MODE_SPLIT)
                    && (timer_mode[dtc_pkg::MOD_CT_ONE]
                    ? cnt_fall[1] : mc_tick);
  // split high half runs on timer 1 run bit, machine cycles
  assign inc_th0  = split && run_bit_one && mc_tick;

  // ****************************************
  // Step function: returns {overflow, high, low}
  // ****************************************
  function automatic logic [16:0] dtc_step(input logic [1:0] m,
                                           input logic [7:0] th,
                                           input logic [7:0] tl);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    logic [16:0] r;
    s13 = {1'b0, th, tl[4:0]} + 14'h1;
    s16 = {1'b0, th, tl} + 17'h1;
    s8  = {1'b0, tl} + 9'h1;
    case (m)
      // 13-bit, upper low-byte bits held at zero
      dtc_pkg::MODE_13BIT:  r = {s13[13], s13[12:5], 3'h0, s13[4:0]};
      dtc_pkg::MODE_16BIT:  r = s16;
      dtc_pkg::MODE_RELOAD: r = s8[8] ? {1'b1, th, th}
                                      : {1'b0, th, s8[7:0]};
      default:              r = {s8[8], th, s8[7:0]};
    endcase
    return r;
  endfunction

  logic [16:0] step_zero;
  logic [16:0] step_one;
  logic [8:0]  step_th0;
  logic        ovf_zero;
  logic        ovf_one;

  assign step_zero = dtc_step(mode_zero, timer0_high_byte, timer0_low_byte);
  assign step_one  = dtc_step(mode_one, timer1_high_byte, timer1_low_byte);
  assign step_th0  = {1'b0, timer0_high_byte} + 9'h1;
  // split halves own the two flags
  assign ovf_zero  = inc_zero && step_zero[16];
  assign ovf_one   = split ? (inc_th0 && step_th0[8])
                           : (inc_one && step_one[16]);

  // ****************************************
  // Timer 0 bytes; a bus write wins over a count
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      timer0_low_byte  <= dtc_pkg::REG_RESET;
      timer0_high_byte <= dtc_pkg::REG_RESET;
    end else begin
      if (wr_tl0) begin
        timer0_low_byte <= sfr_wdata_i;
      end else if (inc_zero) begin
        timer0_low_byte <= step_zero[7:0];
      end
      if (wr_th0) begin
        timer0_high_byte <= sfr_wdata_i;
      end else if (inc_th0) begin
        timer0_high_byte <= step_th0[7:0];
      end else if (inc_zero && !split) begin
        timer0_high_byte <= step_zero[15:8];
      end
    end
  end

  // ****************************************
  // Timer 1 bytes
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      timer1_low_byte  <= dtc_pkg::REG_RESET;
      timer1_high_byte <= dtc_pkg::REG_RESET;
    end else begin
      if (wr_tl1) begin
        timer1_low_byte <= sfr_wdata_i;
      end else if (inc_one) begin
        timer1_low_byte <= step_one[7:0];
      end
      if (wr_th1) begin
        timer1_high_byte <= sfr_wdata_i;
      end else if (inc_one) begin
        timer1_high_byte <= step_one[15:8];
      end
    end
  end

  // ****************************************
  // Mode register
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      timer_mode <= dtc_pkg::REG_RESET;
    end else if (wr_mod) begin
      timer_mode <= sfr_wdata_i;
    end
  end

  // ****************************************
  // Control register: flags where set beats clear
  // ****************************************
  logic set_irq_zero;
  logic set_irq_one;

  // type 1 edge, type 0 low level
  assign set_irq_zero = timer_control[dtc_pkg::CTL_TYPE_ZERO]
                        ? pin_fall[dtc_pkg::PIN_IRQ_ZERO]
                        : !pin_level[dtc_pkg::PIN_IRQ_ZERO];
  assign set_irq_one  = timer_control[dtc_pkg::CTL_TYPE_ONE]
                        ? pin_fall[dtc_pkg::PIN_IRQ_ONE]
                        : !pin_level[dtc_pkg::PIN_IRQ_ONE];

  // Flag updates; the event is never lost to a same-cycle clear
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      timer_control <= dtc_pkg::REG_RESET;
    end else if (ce_i) begin
      if (wr_ctl) begin
        timer_control <= sfr_wdata_i;
      end
      timer_control[dtc_pkg::CTL_OVF_ONE] <= ovf_one
        || (wr_ctl ? sfr_wdata_i[dtc_pkg::CTL_OVF_ONE]
        : (timer_control[dtc_pkg::CTL_OVF_ONE] && !ack_timer_one_i));
      timer_control[dtc_pkg::CTL_OVF_ZERO] <= ovf_zero
        || (wr_ctl ? sfr_wdata_i[dtc_pkg::CTL_OVF_ZERO]
        : (timer_control[dtc_pkg::CTL_OVF_ZERO] && !ack_timer_zero_i));
      timer_control[dtc_pkg::CTL_IRQ_ONE] <= set_irq_one
        || (wr_ctl ? sfr_wdata_i[dtc_pkg::CTL_IRQ_ONE]
        : (timer_control[dtc_pkg::CTL_IRQ_ONE] && !ack_ext_irq_one_i));
      timer_control[dtc_pkg::CTL_IRQ_ZERO] <= set_irq_zero
        || (wr_ctl ? sfr_wdata_i[dtc_pkg::CTL_IRQ_ZERO]
        : (timer_control[dtc_pkg::CTL_IRQ_ZERO] && !ack_ext_irq_zero_i));
    end
  end

  // ****************************************
  // Read port and flag view, both registered
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sfr_rdata_o     <= dtc_pkg::REG_RESET;
      timer_control_o <= dtc_pkg::REG_RESET;
    end else if (ce_i) begin
      timer_control_o <= timer_control;
      if (sfr_re_i) begin
        case (sfr_addr_i)
          dtc_pkg::ADDR_TIMER_CONTROL:    sfr_rdata_o <= timer_control;
          dtc_pkg::ADDR_TIMER_MODE:       sfr_rdata_o <= timer_mode;
          dtc_pkg::ADDR_TIMER0_LOW_BYTE:  sfr_rdata_o <= timer0_low_byte;
          dtc_pkg::ADDR_TIMER1_LOW_BYTE:  sfr_rdata_o <= timer1_low_byte;
          dtc_pkg::ADDR_TIMER0_HIGH_BYTE: sfr_rdata_o <= timer0_high_byte;
          dtc_pkg::ADDR_TIMER1_HIGH_BYTE: sfr_rdata_o <= timer1_high_byte;
          default:                        sfr_rdata_o <= dtc_pkg::REG_RESET;
        endcase
      end else begin
        sfr_rdata_o <= dtc_pkg::REG_RESET;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // timer mode 1 advances by one per machine cycle
  a_mc_increment: assert property (@(posedge mclk_i) disable iff (reset_i)
    (mc_tick && open_zero && !timer_mode[dtc_pkg::MOD_CT_ZERO]
     && mode_zero == dtc_pkg::MODE_16BIT && !wr_tl0 && !wr_th0)
    |=> {timer0_high_byte, timer0_low_byte}
        == $past({timer0_high_byte, timer0_low_byte}) + 16'h1)
    else $error("timer 0 missed a machine cycle count");

  a_tick_spacing: assert property (@(posedge mclk_i)
    disable iff (reset_i || !ce_i) mc_tick |-> ##12 mc_tick)
    else $error("machine cycle ticks not twelve clocks apart");

  // counter mode holds still without an edge
  a_count_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && timer_mode[dtc_pkg::MOD_CT_ONE] && !cnt_fall[1]
     && !wr_tl1 && !wr_th1)
    |=> $stable({timer1_high_byte, timer1_low_byte}))
    else $error("counter 1 moved without a falling edge");

  // edge seen only after high then low sample
  a_edge_samples: assert property (@(posedge mclk_i) disable iff (reset_i)
    cnt_fall[0] |-> (cnt_prev[0] && !cnt_sample[0] && mc_tick))
    else $error("count edge without a one-to-zero sample pair");

  // stopped timer 0 holds its low byte
  a_run_stop: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && !run_bit_zero && !wr_tl0) |=> $stable(timer0_low_byte))
    else $error("timer 0 counted while stopped");

  // mode 0 count clears upper low-byte bits
  a_mode0_low: assert property (@(posedge mclk_i) disable iff (reset_i)
    (inc_zero && mode_zero == dtc_pkg::MODE_13BIT && !wr_tl0)
    |=> timer0_low_byte[7:5] == 3'h0)
    else $error("mode 0 low byte upper bits not zero");

  // reload and flag on low byte overflow
  a_reload: assert property (@(posedge mclk_i) disable iff (reset_i)
    (inc_zero && mode_zero == dtc_pkg::MODE_RELOAD
     && timer0_low_byte == 8'hff && !wr_tl0 && !wr_th0)
    |=> timer0_low_byte == $past(timer0_high_byte)
        && timer_control[dtc_pkg::CTL_OVF_ZERO])
    else $error("mode 2 reload or flag missing");

  // timer 1 frozen in mode 3
  a_t1_halt: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && mode_one == dtc_pkg::MODE_SPLIT && !wr_tl1 && !wr_th1)
    |=> $stable({timer1_high_byte, timer1_low_byte}))
    else $error("timer 1 counted in mode 3");

  // split high half overflow sets timer 1 flag
  a_split_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
    (inc_th0 && timer0_high_byte == 8'hff && !wr_th0)
    |=> timer_control[dtc_pkg::CTL_OVF_ONE] && timer0_high_byte == 8'h00)
    else $error("split high half overflow lost");

  // service clears an idle overflow flag
  a_ack_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ack_timer_zero_i && !ovf_zero && !wr_ctl)
    |=> !timer_control[dtc_pkg::CTL_OVF_ZERO])
    else $error("timer 0 flag survived service");

  // low level in level mode raises the flag
  a_level_irq: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && !timer_control[dtc_pkg::CTL_TYPE_ONE]
     && !pin_level[dtc_pkg::PIN_IRQ_ONE])
    |=> timer_control[dtc_pkg::CTL_IRQ_ONE])
    else $error("level interrupt 1 flag not set");

endmodule

// File: testbench/dtc_pin_model.sv
`timescale 1ns/1ps
// ****************
// Routed pin model
// ****************
module dtc_pin_model (
  // Clock
  input  wire logic mclk_i,
  // Pins toward the timer block
  output logic      cnt0_o,
  output logic      cnt1_o,
  output logic      irq0_o,
  output logic      irq1_o
);
  // Pulled-up pins rest high
  initial begin
    cnt0_o = 1'b1;
    cnt1_o = 1'b1;
    irq0_o = 1'b1;
    irq1_o = 1'b1;
  end

  // each level held two machine cycles
  task automatic fall_cnt(input bit sel, input int n);
    repeat (n) begin
      repeat (24) @(negedge mclk_i);
      if (sel) cnt1_o = 1'b0;
      else cnt0_o = 1'b0;
      repeat (24) @(negedge mclk_i);
      if (sel) cnt1_o = 1'b1;
      else cnt0_o = 1'b1;
    end
  endtask

  // Gating and interrupt levels change off the sampling edge
  task automatic set_irq(input logic l0, input logic l1);
    @(negedge mclk_i);
    irq0_o = l0;
    irq1_o = l1;
  endtask
endmodule

// File: testbench/dual_timer_counter_tb.sv
`timescale 1ns/1ps
module dual_timer_counter_tb;
  logic       mclk, rst, we, re, ce;
  logic [7:0] addr, wdata, rv;
  logic [3:0] ack;
  wire  [7:0] rdata, ctl;
  wire        c0, c1, i0, i1;
  int         err_total, samples_checked, n;
  localparam logic [7:0] CT = dtc_pkg::ADDR_TIMER_CONTROL;
  localparam logic [7:0] MD = dtc_pkg::ADDR_TIMER_MODE;
  localparam logic [7:0] L0 = dtc_pkg::ADDR_TIMER0_LOW_BYTE;
  localparam logic [7:0] L1 = dtc_pkg::ADDR_TIMER1_LOW_BYTE;
  localparam logic [7:0] H0 = dtc_pkg::ADDR_TIMER0_HIGH_BYTE;
  localparam logic [7:0] H1 = dtc_pkg::ADDR_TIMER1_HIGH_BYTE;

  dtc_timer u_dut (.mclk_i(mclk), .reset_i(rst), .ce_i(ce),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_we_i(we), .sfr_re_i(re),
    .sfr_rdata_o(rdata), .count_input_zero_i(c0), .count_input_one_i(c1),
    .external_irq_input_zero_i(i0), .external_irq_input_one_i(i1),
    .ack_timer_zero_i(ack[0]), .ack_timer_one_i(ack[1]),
    .ack_ext_irq_zero_i(ack[2]), .ack_ext_irq_one_i(ack[3]),
    .timer_control_o(ctl));
  dtc_pin_model u_pins (.mclk_i(mclk), .cnt0_o(c0), .cnt1_o(c1),
    .irq0_o(i0), .irq1_o(i1));

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ****************
  // Bus and check tasks
  // ****************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge mclk);
    we = 1'b0;
  endtask
  // Data stands one cycle after the read edge; take it mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    addr = a;
    re = 1'b1;
    @(negedge mclk);
    d = rdata;
    re = 1'b0;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk8(d, e);
  endtask
  // Bounded wait on a flag of the control view
  task automatic wflag(input int b, input int lim, output int c);
    c = 0;
    while (ctl[b] !== 1'b1 && c < lim) begin
      @(negedge mclk);
      c++;
    end
  endtask
  task automatic pulse(input int k);
    @(negedge mclk);
    ack[k] = 1'b1;
    @(negedge mclk);
    ack[k] = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog: tests need well under 10k cycles
  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  // ****************
  // Test sequence
  // ****************
  initial begin
    {rst, we, re, ack, addr, wdata} = {1'b1, 2'b0, 4'h0, 16'h0};
    ce = 1'b1;
    err_total = 0;
    samples_checked = 0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    rchk(CT, dtc_pkg::REG_RESET);
    rchk(MD, dtc_pkg::REG_RESET);
    wr(8'h8e, 8'h5a);
    rchk(8'h8e, 8'h00);
    wr(H1, 8'h3c);
    rchk(H1, 8'h3c);
    // 16-bit timer from 0xffe0: 32 ticks of 12 clocks
    wr(MD, 8'h01);
    wr(L0, 8'he0);
    wr(H0, 8'hff);
    wr(CT, 8'h10);
    wflag(5, 500, n);
    wr(CT, 8'h20);
    chk8({7'h0, n >= 370 && n <= 390}, 8'h01);
    rchk(L0, 8'h00);
    rchk(H0, 8'h00);
    wr(CT, 8'h00);
    rchk(CT, 8'h00);
    // 13-bit: low byte only keeps five bits
    wr(MD, 8'h00);
    wr(L0, 8'h1f);
    wr(H0, 8'hff);
    wr(CT, 8'h10);
    wflag(5, 30, n);
    wr(CT, 8'h20);
    rchk(CT, 8'h20);
    rchk(L0, 8'h00);
    // Auto reload, both timers in mode 2
    wr(MD, 8'h22);
    wr(L0, 8'hff);
    wr(H0, 8'ha5);
    wr(CT, 8'h00);
    wr(CT, 8'h10);
    wflag(5, 30, n);
    wr(CT, 8'h20);
    rchk(L0, 8'ha5);
    pulse(0);
    rchk(CT, 8'h00);
    // Split mode: high half runs on timer 1 run bit
    wr(MD, 8'h33);
    wr(L1, 8'h10);
    wr(L0, 8'h00);
    wr(H0, 8'hff);
    wr(CT, 8'h40);
    wflag(7, 30, n);
    wr(CT, 8'h80);
    rchk(CT, 8'h80);
    rchk(L1, 8'h10);
    rchk(L0, 8'h00);
    pulse(1);
    rchk(CT, 8'h00);
    // Counter operation on both pins
    wr(MD, 8'h55);
    wr(L0, 8'h00);
    wr(L1, 8'h00);
    wr(CT, 8'h50);
    u_pins.fall_cnt(1'b0, 3);
    u_pins.fall_cnt(1'b1, 2);
    repeat (30) @(negedge mclk);
    rchk(L0, 8'h03);
    rchk(L1, 8'h02);
    // Gated timer 0
    wr(CT, 8'h00);
    wr(MD, 8'h09);
    wr(L0, 8'h00);
    u_pins.set_irq(1'b0, 1'b1);
    wr(CT, 8'h10);
    repeat (60) @(negedge mclk);
    rchk(L0, 8'h00);
    u_pins.set_irq(1'b1, 1'b1);
    repeat (60) @(negedge mclk);
    rd(L0, rv);
    chk8({7'h0, rv >= 8'h04}, 8'h01);
    // Clock enable low: a bus write is frozen out
    @(negedge mclk);
    ce = 1'b0;
    wr(L1, 8'h77);
    ce = 1'b1;
    rchk(L1, 8'h02);
    // Edge then level triggered external interrupts
    wr(CT, 8'h05);
    u_pins.set_irq(1'b0, 1'b0);
    wflag(3, 20, n);
    rchk(CT, 8'h0f);
    pulse(2);
    pulse(3);
    rchk(CT, 8'h05);
    wr(CT, 8'h00);
    repeat (4) @(negedge mclk);
    rchk(CT, 8'h0a);
    complete_run();
  end
endmodule
